/* verilog/din_pkg.sv */
`default_nettype none
package din_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] OFS_STATE      = 8'h00;  // Channel states (read)
  localparam logic [7:0] OFS_HOLD_SEL   = 8'h04;  // Held mode select
  localparam logic [7:0] OFS_REL_MODE   = 8'h08;  // Release mode select
  localparam logic [7:0] OFS_CNT_EN     = 8'h0C;  // Count output enable
  localparam logic [7:0] OFS_LINE_FAULT_CHECK_ENABLE     = 8'h10;  // Line fault check enable
  localparam logic [7:0] OFS_QUAL       = 8'h14;  // Quality flags (read)
  localparam logic [7:0] OFS_IRQ_STAT   = 8'h18;  // Sticky events, W1C
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h1C;  // Event mask
  localparam logic [7:0] OFS_CFG        = 8'h20;  // Module config bits
  localparam logic [7:0] OFS_DELAY_BASE = 8'h40;  // Settle delay, one per channel
  localparam logic [7:0] OFS_COUNT_BASE = 8'h80;  // Pulse count, one per channel

  // ****************************************
  // Reset values and field layout
  // ****************************************
  localparam logic [31:0] RST_ZERO     = 32'h0000_0000;
  localparam int          CFG_PRESENT  = 0;  // Module present in slot
  localparam int          CFG_TYPE_OK  = 1;  // Module type correct
  localparam int          CFG_COMM_OK  = 2;  // Controller link alive
  localparam int          IRQ_CHG_BIT  = 0;  // State change event
  localparam int          IRQ_QUAL_BIT = 1;  // Quality raised event
  localparam int          IRQ_WRAP_BIT = 2;  // Counter wrap event

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ         = 250_000_000;
  localparam int STEP_MS        = 2;     // Settle delay step
  localparam int STEP_CYC       = CLK_HZ / 1000 * STEP_MS;
  localparam int BYPASS_HZ      = 1000;  // Bandwidth with filter bypassed
  localparam int BYPASS_CYC     = CLK_HZ / (2 * BYPASS_HZ);
  localparam int MAX_STEPS      = 256;   // 512 ms in 2 ms steps

  // ****************************************
  // Bus carriers
  // ****************************************
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } wr_req_t;

  typedef struct packed {
    logic [1:0]  resp;
    logic [31:0] data;
  } rd_rsp_t;

endpackage
`default_nettype wire

/* verilog/discrete_input_channel_logic.sv */
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module discrete_input_channel_logic #(
  parameter int NCH       = 16,                  // Channel count, 8 or 16
  parameter int STEP_CYCS = din_pkg::STEP_CYC,   // Cycles per 2 ms step
  parameter int BYP_CYCS  = din_pkg::BYPASS_CYC  // Cycles per bypass sample
) (
  input  wire logic            ref_clk_i,
  input  wire logic            reset_n_i,
  input  wire logic [NCH-1:0]  chan_in_i,         // Field inputs
  input  wire logic [NCH-1:0]  release_input_i,   // Release inputs
  input  wire logic [NCH-1:0]  line_fault_i,      // Line fault detect
  input  wire logic            conv_fail_i,       // Converter failure
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  input  wire logic [7:0]      s_axi_awaddr,
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  output logic [1:0]           s_axi_bresp,
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  input  wire logic [7:0]      s_axi_araddr,
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready,
  output logic [31:0]          s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  output logic [NCH-1:0]       channel_state_output_o,
  output logic [NCH-1:0]       channel_quality_flag_o,
  output logic                 converter_quality_flag_o,
  output logic                 irq_o
);
  // ****************************************
  // Reset synchroniser and input sync
  // ****************************************
  logic [1:0]     rst_sync_q;  // Reset release stages
  logic           rst_n;       // Synchronised reset
  logic [NCH-1:0] in_s1_q;     // Input first stage
  logic [NCH-1:0] in_s2_q;     // Input second stage
  logic [NCH-1:0] rel_s1_q;    // Release first stage
  logic [NCH-1:0] rel_s2_q;    // Release second stage
  logic [NCH-1:0] rel_s3_q;    // Release edge history
  logic [NCH-1:0] lf_s1_q;     // Line fault first stage
  logic [NCH-1:0] lf_s2_q;     // Line fault second stage
  logic [1:0]     cf_s_q;      // Converter fail stages
  // Release reset after two edges
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];
  // Two-stage sync of all pins
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      in_s1_q  <= '0;
      in_s2_q  <= '0;
      rel_s1_q <= '0;
      rel_s2_q <= '0;
      rel_s3_q <= '0;
      lf_s1_q  <= '0;
      lf_s2_q  <= '0;
      cf_s_q   <= 2'h0;
    end else begin
      in_s1_q  <= chan_in_i;
      in_s2_q  <= in_s1_q;
      rel_s1_q <= release_input_i;
      rel_s2_q <= rel_s1_q;
      rel_s3_q <= rel_s2_q;
      lf_s1_q  <= line_fault_i;
      lf_s2_q  <= lf_s1_q;
      cf_s_q   <= {cf_s_q[0], conv_fail_i};
    end
  end
  // ****************************************
  // Tick dividers
  // ****************************************
  logic [31:0] step_cnt_q;  // 2 ms divider
  logic [31:0] byp_cnt_q;   // Bypass sample divider
  logic        step_tick;   // One pulse per 2 ms
  logic        byp_tick;    // Bypass sample pulse
  assign step_tick = (step_cnt_q == 32'(STEP_CYCS - 1));
  assign byp_tick  = (byp_cnt_q == 32'(BYP_CYCS - 1));
  // Free running dividers
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      step_cnt_q <= din_pkg::RST_ZERO;
      byp_cnt_q  <= din_pkg::RST_ZERO;
    end else begin
      step_cnt_q <= step_tick ? din_pkg::RST_ZERO : step_cnt_q + 32'h1;
      byp_cnt_q  <= byp_tick ? din_pkg::RST_ZERO : byp_cnt_q + 32'h1;
    end
  end
  // ****************************************
  // Registers
  // ****************************************
  logic [NCH-1:0] hold_high_select_q;     // Held mode per channel
  logic [NCH-1:0] release_mode_q;         // 1 = release on input edge
  logic [NCH-1:0] count_output_enable_q;  // Count visible
  logic [NCH-1:0] line_fault_check_enable_q;
  logic [8:0]     settle_delay_setting_q [NCH];  // Steps of 2 ms, 0 bypass, 256 max
  logic [2:0]     cfg_q;                  // Module present, type, link
  logic [2:0]     irq_stat_q;             // Sticky events
  logic [2:0]     irq_mask_q;             // Event enables
  logic [15:0]    count_q [NCH];          // Pulse counters
  logic [NCH-1:0] filt_q;                 // Filtered levels
  logic [NCH-1:0] held_q;                 // Held reported levels
  logic [8:0]     stab_q [NCH];           // Stable step counters
  // ****************************************
  // AXI4-Lite write path
  // ****************************************
  logic              aw_got_q;  // Address captured
  logic              w_got_q;   // Data captured
  din_pkg::wr_req_t  wr_q;      // Captured write
  logic              wr_fire;   // Both halves present
  assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_q && !s_axi_bvalid;
  assign wr_fire       = aw_got_q && w_got_q && !s_axi_bvalid;
  assign s_axi_bresp   = 2'h0;
  // Capture address and data in any order
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      aw_got_q     <= 1'b0;
      w_got_q      <= 1'b0;
      wr_q         <= '0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q   <= 1'b1;
        wr_q.addr  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q    <= 1'b1;
        wr_q.data  <= s_axi_wdata;
        wr_q.strb  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // Byte-lane merge of a write word
  function automatic logic [31:0] merge(input logic [31:0] old, input din_pkg::wr_req_t w);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (w.strb[b]) begin
        r[8*b +: 8] = w.data[8*b +: 8];
      end
    end
    return r;
  endfunction
  // Writable configuration registers
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      hold_high_select_q        <= '0;
      release_mode_q            <= '0;
      count_output_enable_q     <= '0;
      line_fault_check_enable_q <= '0;
      irq_mask_q                <= 3'h0;
      cfg_q                     <= 3'h0;
      for (int c = 0; c < NCH; c++) begin
        settle_delay_setting_q[c] <= 9'h000;
      end
    end else if (wr_fire) begin
      unique case (wr_q.addr)
        din_pkg::OFS_HOLD_SEL: hold_high_select_q <= NCH'(merge(32'(hold_high_select_q), wr_q));
        din_pkg::OFS_REL_MODE: release_mode_q <= NCH'(merge(32'(release_mode_q), wr_q));
        din_pkg::OFS_CNT_EN:   count_output_enable_q <= NCH'(merge(32'(count_output_enable_q), wr_q));
        din_pkg::OFS_LINE_FAULT_CHECK_ENABLE:   line_fault_check_enable_q <= (NCH == 16) ?
                                 NCH'(merge(32'(line_fault_check_enable_q), wr_q)) : '0;
        din_pkg::OFS_IRQ_MASK: irq_mask_q <= 3'(merge(32'(irq_mask_q), wr_q));
        din_pkg::OFS_CFG:      cfg_q <= 3'(merge(32'(cfg_q), wr_q));
        default: begin
          for (int c = 0; c < NCH; c++) begin
            if (wr_q.addr == din_pkg::OFS_DELAY_BASE + 8'(4 * c)) begin
              settle_delay_setting_q[c] <= 9'(merge(32'(settle_delay_setting_q[c]), wr_q));
            end
          end
        end
      endcase
    end
  end
  // ****************************************
  // AXI4-Lite read path
  // ****************************************
  logic [31:0]    rd_word;    // Decoded read data
  logic [NCH-1:0] rd_clear;   // Auto-release on state read
  logic           rd_fire;    // Read taken
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;
  assign s_axi_rresp   = 2'h0;
  // Read mux
  always_comb begin
    rd_word = din_pkg::RST_ZERO;
    unique case (s_axi_araddr)
      din_pkg::OFS_STATE:    rd_word = 32'(channel_state_output_o);
      din_pkg::OFS_HOLD_SEL: rd_word = 32'(hold_high_select_q);
      din_pkg::OFS_REL_MODE: rd_word = 32'(release_mode_q);
      din_pkg::OFS_CNT_EN:   rd_word = 32'(count_output_enable_q);
      din_pkg::OFS_LINE_FAULT_CHECK_ENABLE:   rd_word = 32'(line_fault_check_enable_q);
      din_pkg::OFS_QUAL:     rd_word = {15'h0000, converter_quality_flag_o,
                                        16'(channel_quality_flag_o)};
      din_pkg::OFS_IRQ_STAT: rd_word = 32'(irq_stat_q);
      din_pkg::OFS_IRQ_MASK: rd_word = 32'(irq_mask_q);
      din_pkg::OFS_CFG:      rd_word = 32'(cfg_q);
      default: begin
        for (int c = 0; c < NCH; c++) begin
          if (s_axi_araddr == din_pkg::OFS_DELAY_BASE + 8'(4 * c)) begin
            rd_word = 32'(settle_delay_setting_q[c]);
          end
          if (s_axi_araddr == din_pkg::OFS_COUNT_BASE + 8'(4 * c)) begin
            rd_word = count_output_enable_q[c] ? 32'(count_q[c]) : din_pkg::RST_ZERO;
          end
        end
      end
    endcase
  end
  // State read auto-releases held channels whose release mode bit is 0
  assign rd_clear = (rd_fire && s_axi_araddr == din_pkg::OFS_STATE) ?
                    ~release_mode_q : '0;
  // Read data register
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= din_pkg::RST_ZERO;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  // ****************************************
  // Channel filter, hold and counter
  // ****************************************
  logic [NCH-1:0] rise;      // Filtered rising edge
  logic [NCH-1:0] rel_edge;  // Release input rising edge
  logic [NCH-1:0] wrap;      // Counter overflow this cycle
  logic [NCH-1:0] filt_d;    // Next filtered level
  assign rel_edge = rel_s2_q & ~rel_s3_q & release_mode_q;
  // Settle filter per channel
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      filt_d[c] = filt_q[c];
      if (settle_delay_setting_q[c] == 9'h000) begin
        if (byp_tick) begin
          filt_d[c] = in_s2_q[c];
        end
      end else if (step_tick && in_s2_q[c] != filt_q[c] &&
                   stab_q[c] + 9'h1 >= settle_delay_setting_q[c]) begin
        filt_d[c] = in_s2_q[c];
      end
    end
  end
  // Stability counters and filtered levels
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      filt_q <= '0;
      for (int c = 0; c < NCH; c++) begin
        stab_q[c] <= 9'h000;
      end
    end else begin
      filt_q <= filt_d;
      for (int c = 0; c < NCH; c++) begin
        if (in_s2_q[c] == filt_q[c] || filt_d[c] != filt_q[c]) begin
          stab_q[c] <= 9'h000;  // Restart on bounce or accept
        end else if (step_tick) begin
          stab_q[c] <= stab_q[c] + 9'h1;
        end
      end
    end
  end
  assign rise = filt_d & ~filt_q;
  // Held level: set on high, released by read or edge
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      held_q <= '0;
    end else begin
      held_q <= (held_q & ~rd_clear & ~rel_edge) | filt_d;
    end
  end
  // Reported state
  assign channel_state_output_o = (hold_high_select_q & held_q) |
                                  (~hold_high_select_q & filt_q);
  // Pulse counters, one per channel
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int c = 0; c < NCH; c++) begin
        count_q[c] <= 16'h0000;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (rise[c]) begin
          count_q[c] <= count_q[c] + 16'h0001;
        end
      end
    end
  end

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      wrap[c] = rise[c] && count_q[c] == 16'hFFFF;
    end
  end
  // ****************************************
  // Quality flags
  // ****************************************
  logic module_bad;  // Slot, type or link fault
  assign module_bad = !cfg_q[din_pkg::CFG_PRESENT] || !cfg_q[din_pkg::CFG_TYPE_OK] ||
                      !cfg_q[din_pkg::CFG_COMM_OK];
  // Registered quality outputs
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      channel_quality_flag_o   <= '1;
      converter_quality_flag_o <= 1'b0;
    end else begin
      channel_quality_flag_o   <= {NCH{module_bad}} |
                                  (line_fault_check_enable_q & lf_s2_q);
      converter_quality_flag_o <= cf_s_q[1];
    end
  end
  // ****************************************
  // Interrupts
  // ****************************************
  logic [NCH-1:0] qual_d;  // Quality flags of the next cycle
  logic [2:0]     ev;      // Events this cycle
  assign qual_d = {NCH{module_bad}} | (line_fault_check_enable_q & lf_s2_q);
  assign ev     = {|wrap, |(qual_d & ~channel_quality_flag_o), |(filt_d ^ filt_q)};
  // Sticky status, set beats write-one clear
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_q <= 3'h0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~((wr_fire && wr_q.addr == din_pkg::OFS_IRQ_STAT &&
                    wr_q.strb[0]) ? wr_q.data[2:0] : 3'h0)) | ev;
    end
  end

  assign irq_o = |(irq_stat_q & irq_mask_q);

endmodule

`default_nettype wire

/* bench/din_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************
// Port relation checks
// ****************
module din_checker #(
  parameter int NCH = 16  // Channel count
) (
  input wire logic           ref_clk_i,
  input wire logic           reset_n_i,
  input wire logic           conv_fail_i,
  input wire logic           s_axi_awvalid,
  input wire logic           s_axi_awready,
  input wire logic           s_axi_wvalid,
  input wire logic           s_axi_wready,
  input wire logic           s_axi_bvalid,
  input wire logic           s_axi_bready,
  input wire logic [1:0]     s_axi_bresp,
  input wire logic           s_axi_arvalid,
  input wire logic           s_axi_arready,
  input wire logic           s_axi_rvalid,
  input wire logic           s_axi_rready,
  input wire logic [1:0]     s_axi_rresp,
  input wire logic [NCH-1:0] channel_state_output_o,
  input wire logic [NCH-1:0] channel_quality_flag_o,
  input wire logic           converter_quality_flag_o,
  input wire logic           irq_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  // Long enough to pass sync stages and reset release
  sequence fail_held; conv_fail_i [*8]; endsequence
  sequence fine_held; !conv_fail_i [*8]; endsequence
  // Both halves of a write taken at one edge
  sequence wr_taken; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  a_conv_flag_set: assert property (fail_held |-> converter_quality_flag_o)
    else $error("converter flag low during failure");
  a_conv_flag_clear: assert property (fine_held |-> !converter_quality_flag_o)
    else $error("converter flag high without failure");
  a_reset_outputs: assert property ($rose(reset_n_i) |->
    channel_state_output_o == '0 && channel_quality_flag_o == '1 && !irq_o)
    else $error("wrong output values at reset release");
  a_write_answer: assert property (wr_taken |=> ##1 s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_write_ends: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_read_ends: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  a_resp_okay: assert property (s_axi_bvalid || s_axi_rvalid |->
    (!s_axi_bvalid || s_axi_bresp == 2'h0) && (!s_axi_rvalid || s_axi_rresp == 2'h0))
    else $error("response code not okay");
  a_busy_refused: assert property (s_axi_bvalid || s_axi_rvalid |->
    (!s_axi_bvalid || !(s_axi_awready || s_axi_wready)) && (!s_axi_rvalid || !s_axi_arready))
    else $error("request taken while answer pending");
endmodule
bind discrete_input_channel_logic din_checker #(.NCH(NCH)) din_checker_i (.*);
`default_nettype wire

/* bench/ctl_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************
// Polling controller, bus master side
// ****************
module ctl_model (
  input  wire logic        ref_clk_i,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  output logic [7:0]       s_axi_araddr,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready,
  input  wire logic [31:0] s_axi_rdata
);
  // Idle bus at time zero, full words only
  initial begin
    s_axi_awvalid = 1'b0;
    s_axi_awaddr  = 8'h00;
    s_axi_wvalid  = 1'b0;
    s_axi_wdata   = 32'h0000_0000;
    s_axi_wstrb   = 4'hF;
    s_axi_bready  = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_araddr  = 8'h00;
    s_axi_rready  = 1'b0;
  end
  // Write; each half released when taken, payload scrambled after
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr  <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata  <= ~d;
      end
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  // Read; data taken at the edge rvalid is seen
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr  <= ~a;
      end
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* bench/discrete_input_channel_logic_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************
// Testbench top
// ****************
module discrete_input_channel_logic_tb_top;
  localparam int NCH  = 16;  // Channel count
  localparam int STEP = 4;   // Short settle step
  localparam int BYP  = 2;   // Short bypass sample
  logic           ref_clk_i = 1'b0;  // Bench clock
  logic           reset_n_i;
  logic [NCH-1:0] chan_in_i;
  logic [NCH-1:0] release_input_i;
  logic [NCH-1:0] line_fault_i;
  logic           conv_fail_i;
  wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  wire logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  wire logic [7:0]     s_axi_awaddr, s_axi_araddr;
  wire logic [31:0]    s_axi_wdata, s_axi_rdata;
  wire logic [3:0]     s_axi_wstrb;
  wire logic [1:0]     s_axi_bresp, s_axi_rresp;
  wire logic [NCH-1:0] channel_state_output_o, channel_quality_flag_o;
  wire logic           converter_quality_flag_o, irq_o;
  int          mismatches;  // Failed compares
  int          checks;      // All compares
  logic [31:0] rdv;         // Last read word
  discrete_input_channel_logic #(.NCH(NCH), .STEP_CYCS(STEP), .BYP_CYCS(BYP))
    discrete_input_channel_logic_i (.*);
  ctl_model ctl_model_i (.*);
  // Free running clock
  always #2 ref_clk_i = ~ref_clk_i;
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    ctl_model_i.rd(a, rdv);
    chk(rdv, exp);
  endtask
  // One high-then-low pulse on a field input
  task automatic pulse(input int ch, input int n);
    chan_in_i[ch] <= 1'b1;
    cyc(n);
    chan_in_i[ch] <= 1'b0;
    cyc(n);
  endtask
  // Reset values, unmapped place, three quality causes
  task automatic t_quality;
    rchk(din_pkg::OFS_QUAL, 32'h0000_FFFF);
    ctl_model_i.wr(8'h3C, 32'hFFFF_FFFF);
    rchk(8'h3C, 32'h0000_0000);
    for (int b = 0; b < 3; b++) begin
      ctl_model_i.wr(din_pkg::OFS_CFG, 32'h0000_0007);
      cyc(6);
      chk(32'(channel_quality_flag_o), 32'h0000_0000);
      ctl_model_i.wr(din_pkg::OFS_CFG, 32'h0000_0007 & ~(32'h1 << b));
      cyc(6);
      chk(32'(channel_quality_flag_o), 32'h0000_FFFF);
    end
    ctl_model_i.wr(din_pkg::OFS_CFG, 32'h0000_0007);
    ctl_model_i.wr(din_pkg::OFS_LINE_FAULT_CHECK_ENABLE, 32'h0000_0008);
    line_fault_i <= 16'h0018;
    cyc(6);
    chk(32'(channel_quality_flag_o), 32'h0000_0008);
    line_fault_i <= 16'h0000;
    conv_fail_i  <= 1'b1;
    cyc(8);
    chk(32'(converter_quality_flag_o), 32'h1);
    rchk(din_pkg::OFS_QUAL, 32'h0001_0000);
    conv_fail_i <= 1'b0;
    cyc(8);
    chk(32'(converter_quality_flag_o), 32'h0);
    $display("t_quality done");
  endtask
  // Bypassed channels follow, filtered channel waits
  task automatic t_filter;
    chan_in_i <= 16'hA5C3;
    cyc(12);
    chk(32'(channel_state_output_o), 32'h0000_A5C3);
    rchk(din_pkg::OFS_STATE, 32'h0000_A5C3);
    chan_in_i <= 16'h0000;
    ctl_model_i.wr(din_pkg::OFS_DELAY_BASE + 8'h04, 32'h0000_0100);
    rchk(din_pkg::OFS_DELAY_BASE + 8'h04, 32'h0000_0100);
    ctl_model_i.wr(din_pkg::OFS_DELAY_BASE, 32'h0000_0003);
    cyc(12);
    pulse(0, 6);
    cyc(20);
    chk(32'(channel_state_output_o[0]), 32'h0);
    chan_in_i[0] <= 1'b1;
    cyc(6);
    chk(32'(channel_state_output_o[0]), 32'h0);
    cyc(30);
    chk(32'(channel_state_output_o[0]), 32'h1);
    ctl_model_i.wr(din_pkg::OFS_DELAY_BASE + 8'h04, 32'h0000_0000);
    $display("t_filter done");
  endtask
  // Held channels, released by read or by edge
  task automatic t_hold;
    ctl_model_i.wr(din_pkg::OFS_HOLD_SEL, 32'h0000_0006);
    ctl_model_i.wr(din_pkg::OFS_REL_MODE, 32'h0000_0004);
    pulse(1, 8);
    pulse(2, 8);
    cyc(6);
    chk(32'(channel_state_output_o[2:1]), 32'h3);
    rchk(din_pkg::OFS_STATE, 32'h0000_0007);
    cyc(4);
    chk(32'(channel_state_output_o[2:1]), 32'h2);
    release_input_i[2] <= 1'b1;
    cyc(6);
    chk(32'(channel_state_output_o[2:1]), 32'h0);
    release_input_i[2] <= 1'b0;
    ctl_model_i.wr(din_pkg::OFS_HOLD_SEL, 32'h0000_0000);
    $display("t_hold done");
  endtask
  // Pulse counts, shown only when enabled
  task automatic t_count;
    pulse(5, 8);
    rchk(din_pkg::OFS_COUNT_BASE + 8'h14, 32'h0000_0000);
    ctl_model_i.wr(din_pkg::OFS_CNT_EN, 32'h0000_0010);
    repeat (3) pulse(4, 8);
    rchk(din_pkg::OFS_COUNT_BASE + 8'h10, 32'h0000_0003);
    $display("t_count done");
  endtask
  // Sticky event, mask and write-one clear
  task automatic t_irq;
    ctl_model_i.wr(din_pkg::OFS_IRQ_STAT, 32'h0000_0007);
    pulse(6, 8);
    cyc(2);
    chk(32'(irq_o), 32'h0);
    rchk(din_pkg::OFS_IRQ_STAT, 32'h0000_0001);
    ctl_model_i.wr(din_pkg::OFS_IRQ_MASK, 32'h0000_0001);
    cyc(2);
    chk(32'(irq_o), 32'h1);
    ctl_model_i.wr(din_pkg::OFS_IRQ_STAT, 32'h0000_0001);
    cyc(2);
    chk(32'(irq_o), 32'h0);
    ctl_model_i.wr(din_pkg::OFS_CFG, 32'h0000_0000);
    cyc(4);
    rchk(din_pkg::OFS_IRQ_STAT, 32'h0000_0002);
    chk(32'(irq_o), 32'h0);
    $display("t_irq done");
  endtask
  // Verdict and end of run
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    reset_n_i       = 1'b0;
    chan_in_i       = '0;
    release_input_i = '0;
    line_fault_i    = '0;
    conv_fail_i     = 1'b0;
    mismatches      = 0;
    checks          = 0;
    cyc(4);
    reset_n_i <= 1'b1;
    cyc(5);
    t_quality;
    t_filter;
    t_hold;
    t_count;
    t_irq;
    wrap_up;
  end
  // Hang guard, well past the expected few hundred cycles
  initial begin
    #200000;
    mismatches++;
    wrap_up;
  end
endmodule
`default_nettype wire
